//--- ums_regs.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Four modem change flags set on input change (ring on a rising input only), cleared by reading modem status.
// - Outside loopback, status bits 7..4 show inverted carrier, ring, ready, clear-to-send.
// - In loopback, bits 7..4 follow aux two, aux one, terminal ready, request-to-send.
// - Bit 3 sets on any carrier detect change; resets to zero.
// - Bit 2 sets only when ring indicator input rises low to high.
// - Bit 1 on set-ready change, bit 0 on clear-to-send change; reset zero.
// - Per-channel 8-bit scratch register, read back, no other effect.
// - Divisor is high latch as upper byte, low latch as lower byte.
// - Divisor latches accept writes only while sleep enable bit 4 is clear.
// - One shared mask; bit n zero blocks channel n from global interrupt.
// - Global interrupt high when any channel status and mask bit both set.
// - Shared global status; bit n set while channel n has an interrupt.
// - Transmit count reports free space, not fill level.
// - 64-byte mode uses low seven bits, binary 0 to 64.
// - 256-byte mode: nine-bit count, top bit beside channel status bit 7.
// - Modem control bit 4 selects internal loopback.
// - Modem control bit 6 with line control bit 7 clear maps page 2.
module ums_regs
    import ums_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset
    input wire logic [ADDR_W-1:0] addr, // {channel, offset}
    input wire logic [7:0] wr_data, // Write data
    input wire logic wr_stb, // Write strobe
    input wire logic rd_stb, // Read strobe
    output logic [7:0] rd_data, // Read data, cycle after strobe
    input wire logic [CH_NUM*4-1:0] modem_in_n, // {dcd,ri,dsr,cts} per channel, pins
    input wire logic [CH_NUM-1:0] ch_irq_pend, // Channel interrupt pending
    input wire logic [CH_NUM*CNT_W-1:0] tx_free_cnt, // Free TX FIFO space per channel
    input wire logic [CH_NUM-1:0] fifo_256_mode, // 256-byte FIFO mode per channel
    output logic [CH_NUM*16-1:0] baud_divisor, // Divisor per channel
    output logic [CH_NUM-1:0] loopback_on, // Internal loopback per channel
    output logic [CH_NUM-1:0] tx_free_msb, // Count bit 8 for channel status bit 7
    output logic global_irq, // Global interrupt
    output logic modem_irq // Modem change event interrupt
);
    // ************************************************
    // Decode
    // ************************************************
    logic [CH_W-1:0] acc_ch;
    logic [OFF_W-1:0] acc_off;
    logic [7:0] line_ctrl_ff [CH_NUM];
    logic [7:0] modem_ctrl_ff [CH_NUM];
    logic [7:0] irq_enable_ff [CH_NUM];
    logic [7:0] scratch_ff [CH_NUM];
    logic [7:0] div_low_ff [CH_NUM];
    logic [7:0] div_high_ff [CH_NUM];
    logic [7:0] modem_stat_view [CH_NUM];
    logic [3:0] delta_ff [CH_NUM];
    logic [CH_NUM-1:0] ch_event;
    logic [7:0] girq_mask_ff;
    logic [7:0] girq_stat_ff;
    logic [7:0] mev_stat_ff;
    logic [7:0] mev_mask_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;
    logic global_irq_ff;
    logic modem_irq_ff;
    logic [CH_NUM-1:0] tx_msb_ff;
    ums_page_t acc_page;

    assign acc_ch = addr[ADDR_W-1:OFF_W];
    assign acc_off = addr[OFF_W-1:0];

    always_comb begin
        if (line_ctrl_ff[acc_ch][LINE_PAGE1_BIT]) begin
            acc_page = UMS_PAGE1;
        end else if (modem_ctrl_ff[acc_ch][MCTL_PAGE2_BIT]) begin
            acc_page = UMS_PAGE2;
        end else begin
            acc_page = UMS_PAGE0;
        end
    end

    // Line and modem control stay reachable in every page so software can leave one
    function automatic logic is_any_page(input logic [OFF_W-1:0] off);
        is_any_page = (off == OFF_LINE_CONTROL) || (off == OFF_MODEM_CONTROL);
    endfunction : is_any_page

    // ************************************************
    // Per-channel registers and modem status
    // ************************************************
    genvar ch;
    generate
        for (ch = 0; ch < CH_NUM; ch++) begin : g_ch
            logic sel;
            logic wr_p0;
            logic [3:0] pin_s1_ff;
            logic [3:0] pin_s2_ff;
            logic [3:0] lvl_n;
            logic [3:0] prev_n_ff;
            logic [3:0] chg;
            logic mstat_read;

            assign sel = (acc_ch == CH_W'(ch));
            assign wr_p0 = wr_stb && sel && (acc_page == UMS_PAGE0);
            assign mstat_read = rd_stb && sel && (acc_page == UMS_PAGE0)
                && (acc_off == OFF_MODEM_STATUS);

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    line_ctrl_ff[ch] <= RST_BYTE;
                    modem_ctrl_ff[ch] <= RST_BYTE;
                end else if (wr_stb && sel && is_any_page(acc_off)) begin
                    if (acc_off == OFF_LINE_CONTROL) begin
                        line_ctrl_ff[ch] <= wr_data;
                    end
                    if (acc_off == OFF_MODEM_CONTROL) begin
                        modem_ctrl_ff[ch] <= wr_data;
                    end
                end
            end

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    irq_enable_ff[ch] <= RST_BYTE;
                    scratch_ff[ch] <= RST_BYTE;
                end else if (wr_p0) begin
                    if (acc_off == OFF_IRQ_ENABLE) begin
                        irq_enable_ff[ch] <= wr_data;
                    end
                    if (acc_off == OFF_SCRATCH_PAD) begin
                        scratch_ff[ch] <= wr_data;
                    end
                end
            end

            // Divisor frozen once sleep is enabled: the baud clock may be gated then
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    div_low_ff[ch] <= RST_BYTE;
                    div_high_ff[ch] <= RST_BYTE;
                end else if (wr_stb && sel && (acc_page == UMS_PAGE1)
                    && !irq_enable_ff[ch][IRQ_EN_SLEEP_BIT]) begin
                    if (acc_off == OFF_DIV_LOW) begin
                        div_low_ff[ch] <= wr_data;
                    end
                    if (acc_off == OFF_DIV_HIGH) begin
                        div_high_ff[ch] <= wr_data;
                    end
                end
            end

            assign baud_divisor[ch*16 +: 16] = {div_high_ff[ch], div_low_ff[ch]};

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1_ff <= RST_PINS_N;
                    pin_s2_ff <= RST_PINS_N;
                end else begin
                    pin_s1_ff <= modem_in_n[ch*4 +: 4];
                    pin_s2_ff <= pin_s1_ff;
                end
            end

            // Active-low view {dcd,ri,dsr,cts}; loopback returns inverted control bits
            assign lvl_n = modem_ctrl_ff[ch][MCTL_LOOP_BIT] ?
                ~{modem_ctrl_ff[ch][MCTL_AUX2_BIT], modem_ctrl_ff[ch][MCTL_AUX1_BIT],
                  modem_ctrl_ff[ch][MCTL_DTR_BIT], modem_ctrl_ff[ch][MCTL_RTS_BIT]}
                : pin_s2_ff;

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    prev_n_ff <= RST_PINS_N;
                end else begin
                    prev_n_ff <= lvl_n;
                end
            end

            assign chg[3] = lvl_n[3] ^ prev_n_ff[3];
            assign chg[2] = lvl_n[2] && !prev_n_ff[2];
            assign chg[1] = lvl_n[1] ^ prev_n_ff[1];
            assign chg[0] = lvl_n[0] ^ prev_n_ff[0];
            assign ch_event[ch] = |chg;

            // A change in the same cycle as the clearing read survives
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    delta_ff[ch] <= RST_NIB;
                end else begin
                    delta_ff[ch] <= (mstat_read ? RST_NIB : delta_ff[ch]) | chg;
                end
            end

            assign modem_stat_view[ch] = {~lvl_n, delta_ff[ch]};

            // ************************************************
            // Per-channel checks
            // ************************************************
            // Every channel is watched, so any channel that a test touches is covered
            a_div_sleep_lock: assert property (
                @(posedge clk_sys) disable iff (!rst_n)
                irq_enable_ff[ch][IRQ_EN_SLEEP_BIT] |=> $stable(baud_divisor[ch*16 +: 16]))
                else $error("divisor changed during sleep");
            a_ring_rise_only: assert property (
                @(posedge clk_sys) disable iff (!rst_n)
                (lvl_n[2] == 1'b0 && prev_n_ff[2] == 1'b1 && !mstat_read
                 && !delta_ff[ch][2]) |=> !delta_ff[ch][2])
                else $error("ring flag set on falling input");
            a_carrier_delta: assert property (
                @(posedge clk_sys) disable iff (!rst_n)
                (lvl_n[3] != prev_n_ff[3]) |=> delta_ff[ch][3])
                else $error("carrier change not flagged");
            // Loopback shows the control bits themselves, not their complement
            a_loop_status: assert property (
                @(posedge clk_sys) disable iff (!rst_n)
                modem_ctrl_ff[ch][MCTL_LOOP_BIT] |-> (modem_stat_view[ch][7:4] == {
                    modem_ctrl_ff[ch][MCTL_AUX2_BIT], modem_ctrl_ff[ch][MCTL_AUX1_BIT],
                    modem_ctrl_ff[ch][MCTL_DTR_BIT], modem_ctrl_ff[ch][MCTL_RTS_BIT]}))
                else $error("loopback status mismatch");
        end
    endgenerate

    // ************************************************
    // Shared registers
    // ************************************************
    logic wr_p2;
    logic rd_p2;
    assign wr_p2 = wr_stb && (acc_page == UMS_PAGE2);
    assign rd_p2 = rd_stb && (acc_page == UMS_PAGE2);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            girq_mask_ff <= RST_BYTE;
            mev_mask_ff <= RST_BYTE;
        end else if (wr_p2) begin
            if (acc_off == OFF_GIRQ_MASK) begin
                girq_mask_ff <= wr_data;
            end
            if (acc_off == OFF_MEV_MASK) begin
                mev_mask_ff <= wr_data;
            end
        end
    end

    // Not sticky: the channel owns the source, so status tracks it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            girq_stat_ff <= RST_BYTE;
        end else begin
            girq_stat_ff <= ch_irq_pend;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mev_stat_ff <= RST_BYTE;
        end else if (rd_p2 && acc_off == OFF_MEV_STATUS) begin
            mev_stat_ff <= ch_event;
        end else begin
            mev_stat_ff <= mev_stat_ff | ch_event;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            global_irq_ff <= 1'b0;
            modem_irq_ff <= 1'b0;
        end else begin
            global_irq_ff <= |(girq_stat_ff & girq_mask_ff);
            modem_irq_ff <= |(mev_stat_ff & mev_mask_ff);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_msb_ff <= RST_BYTE;
        end else begin
            for (int i = 0; i < CH_NUM; i++) begin
                tx_msb_ff[i] <= fifo_256_mode[i] && tx_free_cnt[i*CNT_W+8];
            end
        end
    end

    // ************************************************
    // Read path
    // ************************************************
    always_comb begin
        logic [CNT_W-1:0] cnt;
        cnt = tx_free_cnt[acc_ch*CNT_W +: CNT_W];
        nxt_rd_data = RST_BYTE;
        if (acc_off == OFF_LINE_CONTROL) begin
            nxt_rd_data = line_ctrl_ff[acc_ch];
        end else if (acc_off == OFF_MODEM_CONTROL) begin
            nxt_rd_data = modem_ctrl_ff[acc_ch];
        end else begin
            case (acc_page)
                UMS_PAGE0: begin
                    if (acc_off == OFF_IRQ_ENABLE) nxt_rd_data = irq_enable_ff[acc_ch];
                    if (acc_off == OFF_MODEM_STATUS) nxt_rd_data = modem_stat_view[acc_ch];
                    if (acc_off == OFF_SCRATCH_PAD) nxt_rd_data = scratch_ff[acc_ch];
                end
                UMS_PAGE1: begin
                    if (acc_off == OFF_DIV_LOW) nxt_rd_data = div_low_ff[acc_ch];
                    if (acc_off == OFF_DIV_HIGH) nxt_rd_data = div_high_ff[acc_ch];
                end
                UMS_PAGE2: begin
                    if (acc_off == OFF_GIRQ_MASK) nxt_rd_data = girq_mask_ff;
                    if (acc_off == OFF_GIRQ_STATUS) nxt_rd_data = girq_stat_ff;
                    if (acc_off == OFF_MEV_STATUS) nxt_rd_data = mev_stat_ff;
                    if (acc_off == OFF_MEV_MASK) nxt_rd_data = mev_mask_ff;
                    if (acc_off == OFF_TX_FREE) begin
                        if (fifo_256_mode[acc_ch]) begin
                            nxt_rd_data = cnt[7:0];
                        end else begin
                            nxt_rd_data = {1'b0, cnt[TX64_MSB:0]};
                        end
                    end
                end
                default: nxt_rd_data = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= RST_BYTE;
        end else if (rd_stb) begin
            rd_data_ff <= nxt_rd_data;
        end else begin
            rd_data_ff <= RST_BYTE;
        end
    end

    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            loopback_on[i] = modem_ctrl_ff[i][MCTL_LOOP_BIT];
        end
    end

    assign rd_data = rd_data_ff;
    assign global_irq = global_irq_ff;
    assign modem_irq = modem_irq_ff;
    assign tx_free_msb = tx_msb_ff;

    // ************************************************
    // Checks
    // ************************************************
    a_mstat_read_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_stb && acc_page == UMS_PAGE0 && acc_off == OFF_MODEM_STATUS && !ch_event[acc_ch])
        |=> (delta_ff[$past(acc_ch)] == RST_NIB))
        else $error("modem change flags not cleared by read");
    a_global_irq: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (|(girq_stat_ff & girq_mask_ff)) |=> global_irq)
        else $error("global interrupt missing");
    a_mask_block: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ((girq_mask_ff & girq_stat_ff) == RST_BYTE) |=> !global_irq)
        else $error("masked channel raised interrupt");
    a_gstat_track: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (girq_stat_ff == $past(ch_irq_pend)))
        else $error("global status not tracking channels");
    // Write, one idle cycle, then a read of the same scratch pad
    a_scratch_back: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_stb && acc_page == UMS_PAGE0 && acc_off == OFF_SCRATCH_PAD)
        ##1 (!wr_stb && !rd_stb)
        ##1 (rd_stb && acc_page == UMS_PAGE0 && acc_off == OFF_SCRATCH_PAD
             && acc_ch == $past(acc_ch, 2))
        |=> (rd_data == $past(wr_data, 3)))
        else $error("scratch read back wrong");
endmodule : ums_regs

//--- ums_pkg.sv
package ums_pkg;
    // ************************************************
    // Geometry
    // ************************************************
    localparam int CH_NUM = 8;
    localparam int CH_W = 3;
    localparam int OFF_W = 3;
    localparam int ADDR_W = CH_W + OFF_W;
    localparam int CNT_W = 9;

    // ************************************************
    // Register offsets within a channel
    // ************************************************
    // Page 0
    localparam logic [2:0] OFF_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] OFF_LINE_CONTROL = 3'h3;
    localparam logic [2:0] OFF_MODEM_CONTROL = 3'h4;
    localparam logic [2:0] OFF_MODEM_STATUS = 3'h6;
    localparam logic [2:0] OFF_SCRATCH_PAD = 3'h7;
    // Page 1
    localparam logic [2:0] OFF_DIV_LOW = 3'h0;
    localparam logic [2:0] OFF_DIV_HIGH = 3'h1;
    // Page 2
    localparam logic [2:0] OFF_GIRQ_MASK = 3'h0;
    localparam logic [2:0] OFF_GIRQ_STATUS = 3'h1;
    localparam logic [2:0] OFF_TX_FREE = 3'h2;
    localparam logic [2:0] OFF_MEV_STATUS = 3'h5;
    localparam logic [2:0] OFF_MEV_MASK = 3'h6;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int IRQ_EN_SLEEP_BIT = 4;
    localparam int LINE_PAGE1_BIT = 7;
    localparam int MCTL_PAGE2_BIT = 6;
    localparam int MCTL_LOOP_BIT = 4;
    localparam int MCTL_AUX2_BIT = 3;
    localparam int MCTL_AUX1_BIT = 2;
    localparam int MCTL_RTS_BIT = 1;
    localparam int MCTL_DTR_BIT = 0;
    localparam int TX64_MSB = 6;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [3:0] RST_PINS_N = 4'hF;

    typedef enum logic [1:0] {UMS_PAGE0, UMS_PAGE1, UMS_PAGE2} ums_page_t;
endpackage : ums_pkg

//--- ums_pins_model.sv
`timescale 1ns/1ps
// ************************************************
// Modem pins, channel interrupts and transmit FIFO space
// ************************************************
module ums_pins_model
    import ums_pkg::*;
(
    output logic [CH_NUM*4-1:0] modem_in_n, // Modem pins, active low
    output logic [CH_NUM-1:0] ch_irq_pend, // Channel pending interrupts
    output logic [CH_NUM*CNT_W-1:0] tx_free_cnt, // Free transmit space per channel
    output logic [CH_NUM-1:0] fifo_256_mode // Deep FIFO select per channel
);
    // Pins idle high so that reset release shows no change
    initial begin
        modem_in_n = 32'hFFFF_FFFF;
        ch_irq_pend = 8'h00;
        tx_free_cnt = '0;
        fifo_256_mode = 8'h00;
    end

    // Callers step these right after a clock edge
    task automatic set_pin(input int ch, input int idx, input logic val);
        modem_in_n[ch*4+idx] <= val;
    endtask : set_pin

    task automatic set_pend(input logic [CH_NUM-1:0] val);
        ch_irq_pend <= val;
    endtask : set_pend

    task automatic set_tx(input int ch, input logic [CNT_W-1:0] cnt, input logic deep);
        // A shallow FIFO never offers more than 64 places
        tx_free_cnt[ch*CNT_W +: CNT_W] <= (!deep && cnt > 9'h040) ? 9'h040 : cnt;
        fifo_256_mode[ch] <= deep;
    endtask : set_tx
endmodule : ums_pins_model

//--- uart_modem_status_global_irq_regs_tb.sv
`timescale 1ns/1ps
module uart_modem_status_global_irq_regs_tb
    import ums_pkg::*;
;
    typedef struct packed {logic wr; logic [5:0] addr; logic [7:0] data;} ums_row_t;
    logic clk_sys;
    logic rst_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wr_data;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rd_data;
    logic [CH_NUM*4-1:0] modem_in_n;
    logic [CH_NUM-1:0] ch_irq_pend;
    logic [CH_NUM*CNT_W-1:0] tx_free_cnt;
    logic [CH_NUM-1:0] fifo_256_mode;
    logic [CH_NUM*16-1:0] baud_divisor;
    logic [CH_NUM-1:0] loopback_on;
    logic [CH_NUM-1:0] tx_free_msb;
    logic global_irq;
    logic modem_irq;
    int num_errors = 0;
    int checked = 0;
    logic [7:0] d;
    // Divisor rows never program zero
    ums_row_t rows [0:20] = '{
        '{1'b1, 6'h07, 8'hA5}, '{1'b1, 6'h3F, 8'h5A}, '{1'b0, 6'h07, 8'hA5},
        '{1'b0, 6'h3F, 8'h5A}, '{1'b1, 6'h13, 8'h80}, '{1'b1, 6'h10, 8'h34},
        '{1'b1, 6'h11, 8'h12}, '{1'b0, 6'h10, 8'h34}, '{1'b0, 6'h11, 8'h12},
        '{1'b1, 6'h13, 8'h00}, '{1'b1, 6'h11, 8'h10}, '{1'b1, 6'h13, 8'h80},
        '{1'b1, 6'h10, 8'hFF}, '{1'b0, 6'h10, 8'h34}, '{1'b1, 6'h13, 8'h00},
        '{1'b1, 6'h11, 8'h00}, '{1'b1, 6'h05, 8'h77}, '{1'b0, 6'h05, 8'h00},
        '{1'b0, 6'h07, 8'hA5}, '{1'b1, 6'h3F, 8'hC3}, '{1'b0, 6'h3F, 8'hC3}};
    logic [9:0] txc [0:3] = '{10'h040, 10'h300, 10'h2FF, 10'h000};

    ums_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .modem_in_n(modem_in_n),
        .ch_irq_pend(ch_irq_pend), .tx_free_cnt(tx_free_cnt), .fifo_256_mode(fifo_256_mode),
        .baud_divisor(baud_divisor), .loopback_on(loopback_on), .tx_free_msb(tx_free_msb),
        .global_irq(global_irq), .modem_irq(modem_irq));
    ums_pins_model PART (.modem_in_n(modem_in_n), .ch_irq_pend(ch_irq_pend),
        .tx_free_cnt(tx_free_cnt), .fifo_256_mode(fifo_256_mode));

    // ************************************************
    // Bus master and helpers
    // ************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // Trailing edge keeps the strobe from being raised in the step it falls
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(posedge clk_sys);
        v = rd_data;
    endtask : rd

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] e);
        rd(a, d);
        chk(nm, {8'h00, e}, {8'h00, d});
    endtask : rchk

    task automatic results();
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        num_errors++;
        results();
    end

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        rst_n = 1'b0;
        addr = '0;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rchk("mstat_reset", 6'h0E, 8'h00);
        chk("div_reset", 16'h0000, baud_divisor[47:32]);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].data);
            end else begin
                rchk("row_read", rows[i].addr, rows[i].data);
            end
        end
        chk("divisor", 16'h1234, baud_divisor[47:32]);
        // Modem inputs on channel 1; flags need three cycles through the synchroniser
        PART.set_pin(1, 3, 1'b0);
        tick(6);
        rchk("dcd_fall", 6'h0E, 8'h88);
        rchk("mstat_clear", 6'h0E, 8'h80);
        PART.set_pin(1, 2, 1'b0);
        tick(6);
        rchk("ri_fall", 6'h0E, 8'hC0);
        PART.set_pin(1, 2, 1'b1);
        tick(6);
        rchk("ri_rise", 6'h0E, 8'h84);
        PART.set_pin(1, 1, 1'b0);
        PART.set_pin(1, 0, 1'b0);
        tick(6);
        rchk("dsr_cts", 6'h0E, 8'hB3);
        PART.set_pin(1, 3, 1'b1);
        tick(6);
        rchk("dcd_rise", 6'h0E, 8'h38);
        // Loopback on channel 3
        wr(6'h1C, 8'h19);
        rd(6'h1E, d);
        chk("loop_a", 16'h000A, {12'h000, d[7:4]});
        chk("loop_on", 16'h0008, {8'h00, loopback_on});
        wr(6'h1C, 8'h16);
        rd(6'h1E, d);
        chk("loop_b", 16'h0005, {12'h000, d[7:4]});
        wr(6'h1C, 8'h00);
        // Global interrupt through page 2 of channel 0
        wr(6'h04, 8'h40);
        PART.set_pend(8'h05);
        tick(3);
        chk("girq_masked", 16'h0000, {15'h0000, global_irq});
        rchk("gstat", 6'h01, 8'h05);
        rchk("gstat_again", 6'h01, 8'h05);
        wr(6'h00, 8'h04);
        tick(2);
        chk("girq_on", 16'h0001, {15'h0000, global_irq});
        wr(6'h00, 8'h02);
        tick(2);
        chk("girq_off", 16'h0000, {15'h0000, global_irq});
        rchk("gmask", 6'h00, 8'h02);
        wr(6'h00, 8'hFF);
        tick(1);
        chk("girq_all", 16'h0001, {15'h0000, global_irq});
        PART.set_pend(8'h00);
        tick(3);
        chk("girq_fall", 16'h0000, {15'h0000, global_irq});
        rchk("gstat_fall", 6'h01, 8'h00);
        // Free space: {deep, count} with the shallow limit, the deep top, 255 and zero
        foreach (txc[i]) begin
            PART.set_tx(0, txc[i][8:0], txc[i][9]);
            tick(3);
            rchk("tx_count", 6'h02, txc[i][7:0]);
            chk("tx_msb", {15'h0000, txc[i][9] & txc[i][8]}, {15'h0000, tx_free_msb[0]});
        end
        // Modem event interrupt, raised, cleared by read, then masked
        rd(6'h05, d);
        wr(6'h06, 8'h02);
        PART.set_pin(1, 0, 1'b1);
        tick(6);
        chk("mirq_on", 16'h0001, {15'h0000, modem_irq});
        rchk("mev", 6'h05, 8'h02);
        tick(2);
        chk("mirq_clr", 16'h0000, {15'h0000, modem_irq});
        wr(6'h06, 8'h00);
        PART.set_pin(1, 1, 1'b1);
        tick(6);
        chk("mirq_mask", 16'h0000, {15'h0000, modem_irq});
        rchk("mev_masked", 6'h05, 8'h02);
        // Reset in mid-run returns the scratch pad to zero
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        rchk("spr_rst", 6'h07, 8'h00);
        chk("div_rst", 16'h0000, baud_divisor[47:32]);
        results();
    end
endmodule : uart_modem_status_global_irq_regs_tb
